// ===== odlg_regs.v
`timescale 1ns/10ps
`include "odlg_map.vh"

module odlg_regs #(
    parameter NUM_OUT = `ODLG_NUM_OUT
) (
    input  wire                     core_clk,
    input  wire                     arst_n,
    input  wire [`ODLG_ADDR_W-1:0]  reg_addr,
    input  wire [7:0]               reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [7:0]               reg_rdata,
    output reg                      reg_rd_valid,
    output reg                      reg_hit,
    input  wire                     lock_detect_gate_signal,
    input  wire [NUM_OUT-1:0]       ext_power_down,
    output reg  [47:0]              ctrl_flat,
    output reg  [NUM_OUT-1:0]       lock_gate_enable_bit,
    output wire [NUM_OUT-1:0]       drv_enable,
    output wire [NUM_OUT-1:0]       drv_pin_a_on,
    output wire [NUM_OUT-1:0]       drv_pin_b_on
);
    // ****************************************************************
    // Address decode
    // ****************************************************************
    function is_ctrl;
        input [`ODLG_ADDR_W-1:0] a;
        begin
            is_ctrl = (a >= `ODLG_CLOCK_OUTPUT_SIX_CTRL) && (a <= `ODLG_CLOCK_OUTPUT_ELEVEN_CTRL);
        end
    endfunction

    // Control byte of output six plus k within the flat bus
    function [7:0] ctrl_byte;
        input [47:0]  flat;
        input integer k;
        begin
            ctrl_byte = flat[k*8 +: 8];
        end
    endfunction

    function is_mapped;
        input [`ODLG_ADDR_W-1:0] a;
        begin
            is_mapped = is_ctrl(a) || (a == `ODLG_GATE_LOW) || (a == `ODLG_GATE_HIGH);
        end
    endfunction

    // ****************************************************************
    // Write strobes, one per register
    // ****************************************************************
    reg [`ODLG_NUM_CTRL-1:0] ctrl_we;
    reg                      gate_low_we;
    reg                      gate_high_we;

    always @* begin
        ctrl_we      = {`ODLG_NUM_CTRL{1'b0}};
        gate_low_we  = 1'b0;
        gate_high_we = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                `ODLG_CLOCK_OUTPUT_SIX_CTRL:  ctrl_we      = 6'h01;
                `ODLG_CLOCK_OUTPUT_SEVEN_CTRL:  ctrl_we      = 6'h02;
                `ODLG_CLOCK_OUTPUT_EIGHT_CTRL:  ctrl_we      = 6'h04;
                `ODLG_OUT9_CTRL:  ctrl_we      = 6'h08;
                `ODLG_OUT10_CTRL: ctrl_we      = 6'h10;
                `ODLG_CLOCK_OUTPUT_ELEVEN_CTRL: ctrl_we      = 6'h20;
                `ODLG_GATE_LOW:   gate_low_we  = 1'b1;
                `ODLG_GATE_HIGH:  gate_high_we = 1'b1;
                // Unmapped addresses raise no strobe
                default:          ctrl_we      = {`ODLG_NUM_CTRL{1'b0}};
            endcase
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_flat[7:0]   <= `ODLG_CTRL_RST;
            ctrl_flat[15:8]  <= `ODLG_CTRL_RST;
            ctrl_flat[23:16] <= `ODLG_CTRL_RST;
            ctrl_flat[31:24] <= `ODLG_CTRL_RST;
            ctrl_flat[39:32] <= `ODLG_CTRL_RST;
            ctrl_flat[47:40] <= `ODLG_CTRL_RST;
        end else begin
            if (ctrl_we[0]) begin
                ctrl_flat[7:0] <= reg_wdata;
            end
            if (ctrl_we[1]) begin
                ctrl_flat[15:8] <= reg_wdata;
            end
            if (ctrl_we[2]) begin
                ctrl_flat[23:16] <= reg_wdata;
            end
            if (ctrl_we[3]) begin
                ctrl_flat[31:24] <= reg_wdata;
            end
            if (ctrl_we[4]) begin
                ctrl_flat[39:32] <= reg_wdata;
            end
            if (ctrl_we[5]) begin
                ctrl_flat[47:40] <= reg_wdata;
            end
        end
    end

    // ****************************************************************
    // Lock gate registers
    // ****************************************************************
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_gate_enable_bit <= {NUM_OUT{1'b0}};
        end else begin
            if (gate_low_we) begin
                lock_gate_enable_bit[7:0] <= reg_wdata;
            end
            // Upper four bits of the high gate register carry no gating
            if (gate_high_we) begin
                lock_gate_enable_bit[11:8] <= reg_wdata[3:0];
            end
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    reg [7:0] next_rdata;
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `ODLG_CLOCK_OUTPUT_SIX_CTRL:  next_rdata = ctrl_byte(ctrl_flat, 0);
            `ODLG_CLOCK_OUTPUT_SEVEN_CTRL:  next_rdata = ctrl_byte(ctrl_flat, 1);
            `ODLG_CLOCK_OUTPUT_EIGHT_CTRL:  next_rdata = ctrl_byte(ctrl_flat, 2);
            `ODLG_OUT9_CTRL:  next_rdata = ctrl_byte(ctrl_flat, 3);
            `ODLG_OUT10_CTRL: next_rdata = ctrl_byte(ctrl_flat, 4);
            `ODLG_CLOCK_OUTPUT_ELEVEN_CTRL: next_rdata = ctrl_byte(ctrl_flat, 5);
            `ODLG_GATE_LOW:   next_rdata = lock_gate_enable_bit[7:0];
            `ODLG_GATE_HIGH: begin
                next_rdata = {4'h0, lock_gate_enable_bit[11:8]} & `ODLG_GATE_HIGH_MASK;
            end
            // Unmapped addresses read as zero
            default:          next_rdata = 8'h00;
        endcase
    end

    // ****************************************************************
    // Read answer
    // ****************************************************************
    // A read in the same cycle as a write returns the old value
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd;
        end
    end

    // Hit flags any access to a mapped address
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_hit <= 1'b0;
        end else begin
            reg_hit <= (reg_rd | reg_wr) & is_mapped(reg_addr);
        end
    end

    // ****************************************************************
    // Driver enables
    // ****************************************************************
    // Software is expected to run the current-source lock detect mode
    // and enable the pin comparator so the gating signal is meaningful.
    genvar g;
    generate
        // Outputs below six have gating and external power-down only
        for (g = 0; g < `ODLG_FIRST_CTRL_OUT; g = g + 1) begin : gen_plain
            odlg_out_gate #(
                .HAS_CTRL (0)
            ) u_gate (
                .ctrl     (`ODLG_CTRL_RST),
                .gate_en  (lock_gate_enable_bit[g]),
                .lock_sig (lock_detect_gate_signal),
                .ext_pd   (ext_power_down[g]),
                .drv_on   (drv_enable[g]),
                .pin_a_on (drv_pin_a_on[g]),
                .pin_b_on (drv_pin_b_on[g])
            );
        end
        // Outputs six and up add their own control register
        for (g = `ODLG_FIRST_CTRL_OUT; g < NUM_OUT; g = g + 1) begin : gen_ctrl
            odlg_out_gate #(
                .HAS_CTRL (1)
            ) u_gate (
                .ctrl     (ctrl_byte(ctrl_flat, g - `ODLG_FIRST_CTRL_OUT)),
                .gate_en  (lock_gate_enable_bit[g]),
                .lock_sig (lock_detect_gate_signal),
                .ext_pd   (ext_power_down[g]),
                .drv_on   (drv_enable[g]),
                .pin_a_on (drv_pin_a_on[g]),
                .pin_b_on (drv_pin_b_on[g])
            );
        end
    endgenerate
endmodule

// ===== odlg_map.vh
`ifndef ODLG_MAP_VH
`define ODLG_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ODLG_ADDR_W          10
`define ODLG_CLOCK_OUTPUT_SIX_CTRL       10'h0F6
`define ODLG_CLOCK_OUTPUT_SEVEN_CTRL       10'h0F7
`define ODLG_CLOCK_OUTPUT_EIGHT_CTRL       10'h0F8
`define ODLG_OUT9_CTRL       10'h0F9
`define ODLG_OUT10_CTRL      10'h0FA
`define ODLG_CLOCK_OUTPUT_ELEVEN_CTRL      10'h0FB
`define ODLG_GATE_LOW        10'h0FC
`define ODLG_GATE_HIGH       10'h0FD

// ****************************************************************
// Output control fields
// ****************************************************************
`define ODLG_F_TYPE          7
`define ODLG_F_CMOS_HI       6
`define ODLG_F_CMOS_LO       5
`define ODLG_F_POL_HI        4
`define ODLG_F_POL_LO        3
`define ODLG_F_VOD_HI        2
`define ODLG_F_VOD_LO        1
`define ODLG_F_PD            0

// ****************************************************************
// Reset values, read mask and sizes
// ****************************************************************
`define ODLG_CTRL_RST        8'h62
`define ODLG_GATE_RST        8'h00
`define ODLG_GATE_HIGH_MASK  8'h0F
`define ODLG_FIRST_CTRL_OUT  6
`define ODLG_NUM_CTRL        6
`define ODLG_NUM_OUT         12

`endif

// ===== odlg_out_gate.v
`timescale 1ns/10ps
`include "odlg_map.vh"

// ****************************************************************
// Enable of one clock output driver
// ****************************************************************
module odlg_out_gate #(
    parameter HAS_CTRL = 1
) (
    input  wire [7:0] ctrl,
    input  wire       gate_en,
    input  wire       lock_sig,
    input  wire       ext_pd,
    output wire       drv_on,
    output wire       pin_a_on,
    output wire       pin_b_on
);
    wire cmos_mode;
    wire own_on;
    wire gate_ok;

    // Single-ended pair when set, differential otherwise
    assign cmos_mode = ctrl[`ODLG_F_TYPE];
    assign own_on    = (HAS_CTRL == 0) ? 1'b1 :
                       (cmos_mode ? (ctrl[`ODLG_F_CMOS_HI] | ctrl[`ODLG_F_CMOS_LO])
                                  : ~ctrl[`ODLG_F_PD]);
    // Purely combinational: lock loss powers a gate-enabled driver down with no clock
    assign gate_ok   = ~gate_en | lock_sig;
    assign drv_on    = gate_ok & own_on & ~ext_pd;
    assign pin_a_on  = drv_on & (~cmos_mode | ctrl[`ODLG_F_CMOS_LO] | (HAS_CTRL == 0));
    assign pin_b_on  = drv_on & (~cmos_mode | ctrl[`ODLG_F_CMOS_HI] | (HAS_CTRL == 0));
endmodule

// ===== odlg_regs_asserts.sv
`timescale 1ns/10ps
// ****
// Port checks
// ****
module odlg_regs_asserts #(parameter NUM_OUT = 12) (
    input wire               core_clk,
    input wire               arst_n,
    input wire [9:0]         reg_addr,
    input wire [7:0]         reg_wdata,
    input wire               reg_wr,
    input wire               reg_rd,
    input wire [7:0]         reg_rdata,
    input wire               reg_rd_valid,
    input wire               reg_hit,
    input wire               lock_detect_gate_signal,
    input wire [NUM_OUT-1:0] ext_power_down,
    input wire [47:0]        ctrl_flat,
    input wire [NUM_OUT-1:0] lock_gate_enable_bit,
    input wire [NUM_OUT-1:0] drv_enable,
    input wire [NUM_OUT-1:0] drv_pin_a_on,
    input wire [NUM_OUT-1:0] drv_pin_b_on
);
    wire lk = lock_detect_gate_signal;
    wire [NUM_OUT-1:0] ge = lock_gate_enable_bit;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    rd_valid_next_a: assert property (reg_rd |=> reg_rd_valid)
        else $error("read answer missing");
    valid_needs_rd_a: assert property (reg_rd_valid |-> $past(reg_rd))
        else $error("stray read answer");
    gate_low_read_a: assert property (reg_rd && reg_addr == 10'h0FC
        |=> reg_rdata == $past(ge[7:0])) else $error("low gate readback");
    gate_high_read_a: assert property (reg_rd && reg_addr == 10'h0FD
        |=> reg_rdata == {4'h0, $past(ge[11:8])}) else $error("high gate readback");
    gate_high_wr_a: assert property (reg_wr && reg_addr == 10'h0FD
        |=> ge[11:8] == $past(reg_wdata[3:0])) else $error("high gate write");
    ctrl_wr_a: assert property (reg_wr && reg_addr == 10'h0F6
        |=> ctrl_flat[7:0] == $past(reg_wdata)) else $error("control write");
    gated_off_a: assert property (!lk |-> (drv_enable & ge) == '0)
        else $error("gated output on");
    ext_pd_off_a: assert property ((drv_enable & ext_power_down) == '0)
        else $error("powered-down output on");
    low_out_a: assert property (drv_enable[5:0] ==
        (~ext_power_down[5:0] & (~ge[5:0] | {6{lk}}))) else $error("low output enable");
    lvds_pins_a: assert property (drv_enable[6] && !ctrl_flat[7]
        |-> drv_pin_a_on[6] && drv_pin_b_on[6]) else $error("differential pins");
    hit_decode_a: assert property ((reg_rd || reg_wr) |=> reg_hit ==
        $past(reg_addr >= 10'h0F6 && reg_addr <= 10'h0FD)) else $error("register hit flag");
    hit_idle_a: assert property (!(reg_rd || reg_wr) |=> !reg_hit)
        else $error("hit without access");
    cover property (reg_rd && reg_addr == 10'h0FD);
    cover property ($fell(lk) && |ge);
    cover property (reg_wr && reg_addr == 10'h0F6);
endmodule

bind odlg_regs odlg_regs_asserts #(.NUM_OUT(NUM_OUT)) u_chk (.core_clk(core_clk),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_hit(reg_hit),
    .lock_detect_gate_signal(lock_detect_gate_signal), .ext_power_down(ext_power_down),
    .ctrl_flat(ctrl_flat), .lock_gate_enable_bit(lock_gate_enable_bit),
    .drv_enable(drv_enable), .drv_pin_a_on(drv_pin_a_on), .drv_pin_b_on(drv_pin_b_on));

// ===== odlg_host.sv
`timescale 1ns/10ps
// ****
// Serial port host side
// ****
module odlg_host (
    input  wire        core_clk,
    input  wire  [7:0] reg_rdata,
    input  wire        reg_rd_valid,
    output logic [9:0] reg_addr = '0,
    output logic [7:0] reg_wdata = '0,
    output logic       reg_wr = 0,
    output logic       reg_rd = 0
);
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(posedge core_clk);
        #1 reg_wr = 0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge core_clk);
        #1 reg_addr = a;
        reg_rd = 1;
        @(posedge core_clk);
        #1 reg_rd = 0;
        d = (reg_rd_valid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
    logic core_clk = 0, arst_n = 0, lk = 0;
    logic [11:0] pd = '0;
    logic [7:0]  d;
    wire  [9:0]  addr;
    wire  [7:0]  wd, rdat;
    wire         wr, rd, rv, hit;
    wire  [47:0] cf;
    wire  [11:0] gb, en, pa, pb;
    int          miscompares = 0, checks = 0;
    always #5 core_clk = ~core_clk;
    odlg_host host (.core_clk(core_clk), .reg_rdata(rdat), .reg_rd_valid(rv),
        .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd));
    odlg_regs DUT (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wd),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdat), .reg_rd_valid(rv), .reg_hit(hit),
        .lock_detect_gate_signal(lk), .ext_power_down(pd), .ctrl_flat(cf),
        .lock_gate_enable_bit(gb), .drv_enable(en), .drv_pin_a_on(pa), .drv_pin_b_on(pb));
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
        host.rd(a, d);
        chk({4'h0, d}, {4'h0, exp});
    endtask
    // Gate word 0xFA5 loaded; output 10 is CMOS tristate, output 11 drives pin A only
    task automatic gstep(input logic l, input logic [11:0] p);
        logic [11:0] exp;
        @(posedge core_clk);
        #1 lk = l;
        pd = p;
        #1 exp = 12'hBFF & (~12'hFA5 | {12{lk}}) & ~pd;
        chk(en, exp);
        chk(pa, exp);
        chk(pb, exp & 12'h7FF);
    endtask
    task automatic test_done;
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        #1 arst_n = 1;
        for (int i = 0; i < 8; i++) rchk(10'(10'h0F6 + i), i < 6 ? 8'h62 : 8'h00);
        for (int i = 0; i < 6; i++) host.wr(10'(10'h0F6 + i), 8'(8'h22 * i));
        for (int i = 0; i < 6; i++) rchk(10'(10'h0F6 + i), 8'(8'h22 * i));
        host.wr(10'h0FC, 8'hA5);
        host.wr(10'h0FD, 8'hFF);
        chk({11'h000, hit}, 12'h001);
        rchk(10'h0FC, 8'hA5);
        chk({11'h000, hit}, 12'h001);
        rchk(10'h0FD, 8'h0F);
        host.wr(10'h100, 8'h5A);
        chk({11'h000, hit}, 12'h000);
        rchk(10'h100, 8'h00);
        chk({11'h000, hit}, 12'h000);
        gstep(0, 12'h000);
        gstep(1, 12'h000);
        gstep(1, 12'h108);
        gstep(0, 12'h108);
        test_done();
    end
endmodule
